// *** hw/fbw_pkg.sv ***
package fbw_pkg;
    // timing
    localparam int CLK_FREQ_HZ = 10_000_000;      // control clock, 100 ns period
    localparam int WDOG_PERIOD_MS = 500;          // square wave period the master sends
    localparam int WDOG_TIMEOUT_MS = 2 * WDOG_PERIOD_MS; // silence before a bus fault
    localparam int WDOG_TIMEOUT_CYC = CLK_FREQ_HZ / 1000 * WDOG_TIMEOUT_MS;
    localparam int WDOG_CNT_W = 24;               // holds WDOG_TIMEOUT_CYC
    // word geometry
    localparam int WORD_W = 16;
    localparam logic [15:0] WORD_ZERO = 16'h0000; // reset value of every word
    localparam int NUM_VIN = 3;                   // virtual digital inputs
    // bus_command_word bit positions
    localparam int CW_PRECHARGE = 0;
    localparam int CW_RUN = 3;
    localparam int CW_FAULT_RESET = 7;
    localparam int CW_BUS_CONTROL = 10;
    localparam int CW_WATCHDOG = 11;
    localparam int CW_VIN_LO = 12;                // bits 12..14
    // bus_report_word bit positions
    localparam int SW_READY_ON = 0;
    localparam int SW_READY_RUN = 1;
    localparam int SW_RUNNING = 2;
    localparam int SW_FAULT = 3;
    localparam int SW_RUN_ENABLE = 4;
    localparam int SW_QUICK_STOP_N = 5;
    localparam int SW_BREAKER_OK = 6;
    localparam int SW_WARNING = 7;
    localparam int SW_SETPOINT = 8;
    localparam int SW_BUS_CONTROL = 9;
    localparam int SW_ABOVE_LIMIT = 10;
    localparam int SW_PRECHARGE = 14;
    localparam int SW_WATCHDOG = 15;
    // generation_report_word bit positions
    localparam int GS_GEN_SELECTED = 0;
    localparam int GS_DC_CONTROL = 1;
    // fault source indices on the FAULT_SRC input
    localparam int FS_OVERCURRENT = 0;
    localparam int FS_IGBT = 1;
    localparam int FS_OVERVOLT = 2;
    localparam int FS_UNDERVOLT = 3;
    localparam int FS_EARTH = 4;
    localparam int FS_UNIT_TEMP = 5;
    localparam int FS_MOTOR_TEMP = 6;
    localparam int FS_LINE_SYNCH = 7;
    localparam int FS_KEYPAD = 8;
    localparam int FS_FIELDBUS = 9;
    localparam int FS_SYSBUS = 10;
    localparam int FS_SLOT = 11;
    localparam int FS_LOOP_4MA = 12;
    localparam int FS_ENCODER = 13;
    localparam int FS_EXTERNAL = 14;
    localparam int FS_MAIN_SWITCH = 15;
    // fault_flags_first positions
    localparam int F1_OVERCURRENT = 0;
    localparam int F1_OVERVOLT = 1;
    localparam int F1_UNDERVOLT = 2;
    localparam int F1_EARTH = 4;
    localparam int F1_UNIT_TEMP = 6;
    localparam int F1_MOTOR_TEMP = 7;
    localparam int F1_LINE_SYNCH = 8;
    localparam int F1_KEYPAD = 11;
    localparam int F1_FIELDBUS = 12;
    localparam int F1_SYSBUS = 13;
    localparam int F1_SLOT = 14;
    localparam int F1_LOOP_4MA = 15;
    // fault_flags_second positions
    localparam int F2_ENCODER = 2;
    localparam int F2_EXTERNAL = 6;
    localparam int F2_IGBT = 9;
    localparam int F2_MAIN_SWITCH = 14;
    // breaker sequencing states
    typedef enum logic [1:0] {
        BRK_OPEN = 2'b00,
        BRK_PRECHARGE = 2'b01,
        BRK_CLOSED = 2'b10
    } fbw_brk_state_t;
    // relay output source selection
    typedef enum logic [1:0] {
        RLY_OFF = 2'b00,
        RLY_VIN2 = 2'b01,
        RLY_VIN3 = 2'b10,
        RLY_VIN4 = 2'b11
    } fbw_relay_sel_t;
endpackage

// *** hw/fbw_sync.sv ***
`timescale 1ns/1ps
// two-stage synchroniser for levels from outside the clock domain
module fbw_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // data
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);
    logic [W-1:0] meta; // first stage, read only by the second

    // both stages reset to zero, never to the port value
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            meta <= '0;
            Q <= '0;
        end else begin
            meta <= D;
            Q <= meta;
        end
    end
endmodule

// *** hw/fbw_core.sv ***
`timescale 1ns/1ps
// Function
// RQ1 - bit 0 precharges, breaker auto-closes; clear opens
// RQ2 - bit 3 starts or stops the converter
// RQ3 - rising edge of bit 7 clears faults
// RQ4 - bit 10 grants fieldbus command authority
// RQ5 - master toggles bit 11 every half period
// RQ6 - bits 12-14 are three virtual inputs
// RQ7 - status bit 0 shows ready to charge
// RQ8 - status bit 1: ready and breaker closed
// RQ9 - status bit 2 shows modulating run state
// RQ10 - status bit 3 shows any active fault
// RQ11 - status bit 4 shows run enabled
// RQ12 - status bit 5 low while quick stop
// RQ13 - status bit 6: breaker feedback matches command
// RQ14 - status bit 7 shows any warning
// RQ15 - status bit 8: DC voltage equals reference
// RQ16 - status bit 9 shows fieldbus authority
// RQ17 - status bit 10: DC voltage above threshold
// RQ18 - status bit 14 shows precharge active
// RQ19 - status bit 15 echoes received watchdog
// RQ20 - first fault word per fault class
// RQ21 - second fault word per fault class
module fbw_core
    import fbw_pkg::*;
#(
    parameter int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // command word from the fieldbus master
    input wire logic [fbw_pkg::WORD_W-1:0] BUS_COMMAND_WORD,
    // drive state, same clock domain
    input wire logic DRIVE_READY,
    input wire logic DRIVE_MODULATING,
    input wire logic RUN_ENABLE,
    input wire logic QUICK_STOP_ACTIVE,
    input wire logic WARNING_ACTIVE,
    input wire logic GEN_MODE_SELECTED,
    input wire logic [fbw_pkg::WORD_W-1:0] FAULT_SRC,
    // DC link measurement and settings
    input wire logic [fbw_pkg::WORD_W-1:0] DC_MEASURED,
    input wire logic [fbw_pkg::WORD_W-1:0] DC_REFERENCE,
    input wire logic [fbw_pkg::WORD_W-1:0] DC_LIMIT,
    // breaker feedback pin
    input wire logic BREAKER_FEEDBACK,
    // relay routing
    input wire logic [1:0] RELAY_SELECT,
    // contactor and converter commands
    output logic PRECHARGE_REQUEST,
    output logic MAIN_BREAKER,
    output logic RUN_REQUEST,
    // virtual inputs and relay
    output logic BUS_VIRTUAL_INPUT_2,
    output logic BUS_VIRTUAL_INPUT_3,
    output logic BUS_VIRTUAL_INPUT_4,
    output logic RELAY_OUTPUT,
    // report words
    output logic [fbw_pkg::WORD_W-1:0] BUS_REPORT_WORD,
    output logic [fbw_pkg::WORD_W-1:0] GENERATION_REPORT_WORD,
    output logic [fbw_pkg::WORD_W-1:0] FAULT_FLAGS_FIRST,
    output logic [fbw_pkg::WORD_W-1:0] FAULT_FLAGS_SECOND
);
    import fbw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisation

    logic [WORD_W-1:0] cmd; // command word after two flops
    logic feedback; // breaker feedback after two flops

    // the master writes asynchronously to our clock
    fbw_sync #(.W(WORD_W)) u_cmd_sync (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .D(BUS_COMMAND_WORD),
        .Q(cmd)
    );

    fbw_sync #(.W(1)) u_fb_sync (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .D(BREAKER_FEEDBACK),
        .Q(feedback)
    );

    ////////////////////////////////////////////////////////////////////////
    // command decode

    logic authority; // fieldbus holds command authority
    logic charge_cmd; // effective precharge/breaker command
    logic reset_prev; // last value of the fault reset bit
    logic reset_edge; // zero-to-one transition of the reset bit
    logic dc_above; // DC voltage above threshold

    assign authority = cmd[CW_BUS_CONTROL]; // RQ4
    // precharge and run commands count only while the bus has authority
    assign charge_cmd = authority & cmd[CW_PRECHARGE]; // RQ1
    assign reset_edge = cmd[CW_FAULT_RESET] & ~reset_prev; // RQ3
    assign dc_above = DC_MEASURED > DC_LIMIT; // RQ17

    // edge memory for the fault reset bit
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            reset_prev <= 1'b0;
        end else begin
            reset_prev <= cmd[CW_FAULT_RESET];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // breaker sequencing

    fbw_brk_state_t state; // present sequencing state
    fbw_brk_state_t next_state; // state for the next edge

    // precharge first, close the breaker once the link is charged
    always_comb begin
        next_state = state;
        case (state)
            BRK_OPEN: begin
                if (charge_cmd) begin
                    next_state = BRK_PRECHARGE; // RQ1
                end
            end
            BRK_PRECHARGE: begin
                if (!charge_cmd) begin
                    next_state = BRK_OPEN; // RQ1
                end else if (dc_above) begin
                    next_state = BRK_CLOSED; // RQ1
                end
            end
            BRK_CLOSED: begin
                if (!charge_cmd) begin
                    next_state = BRK_OPEN; // RQ1
                end
            end
            default: begin
                next_state = BRK_OPEN; // illegal code falls back safe
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= BRK_OPEN;
        end else begin
            state <= next_state;
        end
    end

    // contactor outputs decoded from the state register
    assign PRECHARGE_REQUEST = (state == BRK_PRECHARGE); // RQ1
    assign MAIN_BREAKER = (state == BRK_CLOSED); // RQ1

    ////////////////////////////////////////////////////////////////////////
    // watchdog supervision

    logic wd_prev; // last watchdog bit seen
    logic [WDOG_CNT_W-1:0] wd_count; // cycles since last toggle
    logic wd_expired; // master went silent

    // only supervised while the bus holds authority
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wd_prev <= 1'b0;
            wd_count <= '0;
        end else begin
            wd_prev <= cmd[CW_WATCHDOG];
            if (!authority || cmd[CW_WATCHDOG] != wd_prev) begin
                wd_count <= '0; // RQ5
            end else if (!wd_expired) begin
                wd_count <= wd_count + 1'b1;
            end
        end
    end

    // saturates so a long silence does not wrap and hide the fault
    assign wd_expired = (wd_count == WDOG_CNT_W'(WDOG_TIMEOUT_CYCLES - 1)); // RQ5

    ////////////////////////////////////////////////////////////////////////
    // fault words

    logic [WORD_W-1:0] src; // sources with the bus watchdog merged
    logic [WORD_W-1:0] next_first; // next first fault word
    logic [WORD_W-1:0] next_second; // next second fault word
    logic fault_any; // any latched fault

    assign src = FAULT_SRC | (WORD_W'(wd_expired) << FS_FIELDBUS);

    // class decode for the first word; IGBT lands in both words
    function automatic logic [WORD_W-1:0] map_first(input logic [WORD_W-1:0] s);
        logic [WORD_W-1:0] w;
        w = WORD_ZERO;
        w[F1_OVERCURRENT] = s[FS_OVERCURRENT] | s[FS_IGBT];
        w[F1_OVERVOLT] = s[FS_OVERVOLT];
        w[F1_UNDERVOLT] = s[FS_UNDERVOLT];
        w[F1_EARTH] = s[FS_EARTH];
        w[F1_UNIT_TEMP] = s[FS_UNIT_TEMP];
        w[F1_MOTOR_TEMP] = s[FS_MOTOR_TEMP];
        w[F1_LINE_SYNCH] = s[FS_LINE_SYNCH];
        w[F1_KEYPAD] = s[FS_KEYPAD];
        w[F1_FIELDBUS] = s[FS_FIELDBUS];
        w[F1_SYSBUS] = s[FS_SYSBUS];
        w[F1_SLOT] = s[FS_SLOT];
        w[F1_LOOP_4MA] = s[FS_LOOP_4MA];
        return w;
    endfunction

    // class decode for the second word
    function automatic logic [WORD_W-1:0] map_second(input logic [WORD_W-1:0] s);
        logic [WORD_W-1:0] w;
        w = WORD_ZERO;
        w[F2_ENCODER] = s[FS_ENCODER];
        w[F2_EXTERNAL] = s[FS_EXTERNAL];
        w[F2_IGBT] = s[FS_IGBT];
        w[F2_MAIN_SWITCH] = s[FS_MAIN_SWITCH];
        return w;
    endfunction

    // a source still present at the reset edge sets its bit again
    assign next_first = (reset_edge ? WORD_ZERO : FAULT_FLAGS_FIRST) | map_first(src); // RQ20
    assign next_second = (reset_edge ? WORD_ZERO : FAULT_FLAGS_SECOND) | map_second(src); // RQ21

    // sticky fault words
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FAULT_FLAGS_FIRST <= WORD_ZERO;
            FAULT_FLAGS_SECOND <= WORD_ZERO;
        end else begin
            FAULT_FLAGS_FIRST <= next_first; // RQ20
            FAULT_FLAGS_SECOND <= next_second; // RQ21
        end
    end

    assign fault_any = |{FAULT_FLAGS_FIRST, FAULT_FLAGS_SECOND}; // RQ10

    ////////////////////////////////////////////////////////////////////////
    // run command and virtual inputs

    logic [NUM_VIN-1:0] vin; // registered virtual inputs

    // no start into a fault or an open breaker
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RUN_REQUEST <= 1'b0;
        end else begin
            RUN_REQUEST <= authority & cmd[CW_RUN] & MAIN_BREAKER & ~fault_any; // RQ2
        end
    end

    // one flop per virtual input
    for (genvar i = 0; i < NUM_VIN; i++) begin : g_vin
        always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
                vin[i] <= 1'b0;
            end else begin
                vin[i] <= cmd[CW_VIN_LO + i]; // RQ6
            end
        end
    end

    assign BUS_VIRTUAL_INPUT_2 = vin[0];
    assign BUS_VIRTUAL_INPUT_3 = vin[1];
    assign BUS_VIRTUAL_INPUT_4 = vin[2];

    // relay follows the selected virtual input
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RELAY_OUTPUT <= 1'b0;
        end else begin
            case (fbw_relay_sel_t'(RELAY_SELECT))
                RLY_VIN2: RELAY_OUTPUT <= cmd[CW_VIN_LO]; // RQ6
                RLY_VIN3: RELAY_OUTPUT <= cmd[CW_VIN_LO + 1]; // RQ6
                RLY_VIN4: RELAY_OUTPUT <= cmd[CW_VIN_LO + 2]; // RQ6
                default: RELAY_OUTPUT <= 1'b0; // relay unused
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // report words

    logic [WORD_W-1:0] next_report; // status word before its flop
    logic [WORD_W-1:0] next_gen; // generation word before its flop

    // assemble status; reserved bits stay zero
    always_comb begin
        next_report = WORD_ZERO;
        next_report[SW_READY_ON] = DRIVE_READY; // RQ7
        next_report[SW_READY_RUN] = DRIVE_READY & MAIN_BREAKER & feedback; // RQ8
        next_report[SW_RUNNING] = DRIVE_MODULATING; // RQ9
        next_report[SW_FAULT] = fault_any; // RQ10
        next_report[SW_RUN_ENABLE] = RUN_ENABLE; // RQ11
        next_report[SW_QUICK_STOP_N] = ~QUICK_STOP_ACTIVE; // RQ12
        next_report[SW_BREAKER_OK] = (feedback == MAIN_BREAKER); // RQ13
        next_report[SW_WARNING] = WARNING_ACTIVE; // RQ14
        next_report[SW_SETPOINT] = (DC_MEASURED == DC_REFERENCE); // RQ15
        next_report[SW_BUS_CONTROL] = authority; // RQ16
        next_report[SW_ABOVE_LIMIT] = dc_above; // RQ17
        next_report[SW_PRECHARGE] = PRECHARGE_REQUEST; // RQ18
        next_report[SW_WATCHDOG] = cmd[CW_WATCHDOG]; // RQ19
        next_gen = WORD_ZERO;
        next_gen[GS_GEN_SELECTED] = GEN_MODE_SELECTED;
        next_gen[GS_DC_CONTROL] = DRIVE_MODULATING;
    end

    // report word flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BUS_REPORT_WORD <= WORD_ZERO;
            GENERATION_REPORT_WORD <= WORD_ZERO;
        end else begin
            BUS_REPORT_WORD <= next_report;
            GENERATION_REPORT_WORD <= next_gen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // command held, then link charged
    sequence charge_start_s;
        state == BRK_OPEN && charge_cmd;
    endsequence
    sequence link_charged_s;
        PRECHARGE_REQUEST && charge_cmd && dc_above;
    endsequence

    precharge_start_a: assert property (charge_start_s |=> PRECHARGE_REQUEST) // RQ1
        else $error("precharge did not start");
    breaker_auto_a: assert property (link_charged_s |=> MAIN_BREAKER && !PRECHARGE_REQUEST) // RQ1
        else $error("breaker did not close after precharge");
    breaker_open_a: assert property (!cmd[CW_PRECHARGE] |=> !MAIN_BREAKER && !PRECHARGE_REQUEST) // RQ1
        else $error("breaker not opened on clear");
    run_request_a: assert property (RUN_REQUEST |-> $past(cmd[CW_RUN]) && $past(authority)) // RQ2
        else $error("run request without start command");
    fault_clear_a: assert property (reset_edge && src == WORD_ZERO |=> !fault_any) // RQ3
        else $error("fault not cleared on reset edge");
    fault_level_a: assert property (fault_any && !reset_edge |=> fault_any) // RQ3
        else $error("fault lost without reset edge");
    bus_authority_a: assert property (!authority ##1 !authority |=> !RUN_REQUEST && !MAIN_BREAKER) // RQ4
        else $error("command acted without authority");
    watchdog_timeout_a: assert property (authority && wd_count == WDOG_CNT_W'(WDOG_TIMEOUT_CYCLES - 2) && $stable(cmd[CW_WATCHDOG]) ##1 $stable(cmd[CW_WATCHDOG]) |=> FAULT_FLAGS_FIRST[F1_FIELDBUS]) // RQ5
        else $error("watchdog silence not flagged");
    virtual_input_a: assert property (##1 BUS_VIRTUAL_INPUT_3 == $past(cmd[CW_VIN_LO + 1])) // RQ6
        else $error("virtual input mismatch");
    ready_run_a: assert property (BUS_REPORT_WORD[SW_READY_RUN] |-> $past(DRIVE_READY) && $past(MAIN_BREAKER)) // RQ8
        else $error("ready-run without closed breaker");
    fault_status_a: assert property (##1 BUS_REPORT_WORD[SW_FAULT] == $past(fault_any)) // RQ10
        else $error("fault status mismatch");
    quick_stop_a: assert property (QUICK_STOP_ACTIVE |=> !BUS_REPORT_WORD[SW_QUICK_STOP_N]) // RQ12
        else $error("quick stop sense wrong");
    watchdog_echo_a: assert property (##1 BUS_REPORT_WORD[SW_WATCHDOG] == $past(cmd[CW_WATCHDOG])) // RQ19
        else $error("watchdog echo mismatch");
    fault_map_a: assert property (FAULT_SRC[FS_IGBT] |=> FAULT_FLAGS_FIRST[F1_OVERCURRENT] && FAULT_FLAGS_SECOND[F2_IGBT]) // RQ20 RQ21
        else $error("igbt fault not mapped");
endmodule

// *** testbench/fbw_master.sv ***
`timescale 1ns/1ps
// fieldbus master: sends the command word and drives the watchdog square wave
module fbw_master #(
    parameter int HALF_CYC = 10
) (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // word wanted by the bench, watchdog toggling on
    input wire logic [15:0] WORD_IN,
    input wire logic TOGGLE,
    // word towards the device
    output logic [15:0] WORD_OUT
);
    int cnt; // cycles since last watchdog edge
    logic wd; // level sent on bit 11
    ////////////////////////////////////////////////////////////////////////////
    // updated by non-blocking assignment on the rising edge, so the bench's
    // falling-edge stimulus never races it and the device's first flop takes
    // the old bit; stopping the toggle is how the bench fakes a dead link
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt <= 0;
            wd <= 1'b0;
        end else if (!TOGGLE) begin
            cnt <= 0;
            wd <= WORD_IN[11];
        end else if (cnt == HALF_CYC - 1) begin
            cnt <= 0;
            wd <= ~wd;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign WORD_OUT = {WORD_IN[15:12], wd, WORD_IN[10:0]};
endmodule

// *** testbench/tb_fieldbus_word_interface.sv ***
`timescale 1ns/1ps
module tb_fieldbus_word_interface;
    import fbw_pkg::*;
    localparam int TO_CYC = 50; // shortened watchdog timeout
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] word = 16'h0000; // word the master is told to send
    logic toggle = 1'b0;
    logic [15:0] cmd;
    logic rdy = 1'b0, mod = 1'b0, ren = 1'b0, qs = 1'b0, warn = 1'b0, gen = 1'b0, fb = 1'b0;
    logic [15:0] fsrc = 16'h0000, dcm = 16'h0000, dcr = 16'h0000, dcl = 16'h0064;
    logic [1:0] rsel = 2'h0;
    logic pre, brk, run, v2, v3, v4, rly;
    logic [15:0] rep, genw, ff1, ff2, acc;
    logic [31:0] ef; // both expected fault words, first one on top
    logic [3:0] mon; // outputs a bounded wait can watch
    int error_cnt = 0;
    int comparisons = 0;
    // fault source index to flag position, -1 where the word has none
    int map1[16] = '{0, 0, 1, 2, 4, 6, 7, 8, 11, 12, 13, 14, 15, -1, -1, -1};
    int map2[16] = '{-1, 9, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, 2, 6, 14};
    assign mon = {ff1[F1_FIELDBUS], run, brk, pre};
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    fbw_master #(.HALF_CYC(10)) fbw_master_inst (.CLK(clk), .ARST_N(arst_n),
        .WORD_IN(word), .TOGGLE(toggle), .WORD_OUT(cmd));
    fbw_core #(.WDOG_TIMEOUT_CYCLES(TO_CYC)) fbw_core_inst (.CLK(clk), .ARST_N(arst_n),
        .BUS_COMMAND_WORD(cmd), .DRIVE_READY(rdy), .DRIVE_MODULATING(mod),
        .RUN_ENABLE(ren), .QUICK_STOP_ACTIVE(qs), .WARNING_ACTIVE(warn),
        .GEN_MODE_SELECTED(gen), .FAULT_SRC(fsrc), .DC_MEASURED(dcm),
        .DC_REFERENCE(dcr), .DC_LIMIT(dcl), .BREAKER_FEEDBACK(fb), .RELAY_SELECT(rsel),
        .PRECHARGE_REQUEST(pre), .MAIN_BREAKER(brk), .RUN_REQUEST(run),
        .BUS_VIRTUAL_INPUT_2(v2), .BUS_VIRTUAL_INPUT_3(v3), .BUS_VIRTUAL_INPUT_4(v4),
        .RELAY_OUTPUT(rly), .BUS_REPORT_WORD(rep), .GENERATION_REPORT_WORD(genw),
        .FAULT_FLAGS_FIRST(ff1), .FAULT_FLAGS_SECOND(ff2));
    ////////////////////////////////////////////////////////////////////////////
    // verdict, the single exit of the run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // one compare for every 16-bit result
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait on one watched output; running out ends the run
    task automatic wait_bit(input string what, input int idx, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if (mon[idx] === lvl) begin
                chk(what, {15'h0, lvl}, {15'h0, mon[idx]});
                return;
            end
        end
        chk(what, {15'h0, lvl}, {15'h0, mon[idx]});
        summarize();
    endtask
    // sticky fault words expected from the set of sources seen so far
    function automatic logic [31:0] exp_faults(input logic [15:0] src);
        logic [15:0] a;
        logic [15:0] b;
        a = 16'h0000;
        b = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (src[i] && map1[i] >= 0) begin
                a[map1[i]] = 1'b1;
            end
            if (src[i] && map2[i] >= 0) begin
                b[map2[i]] = 1'b1;
            end
        end
        return {a, b};
    endfunction
    // status word with the breaker held open and no faults
    function automatic logic [15:0] exp_status(input logic [15:0] w);
        logic [15:0] s;
        s = 16'h0000;
        s[SW_READY_ON] = rdy;
        s[SW_RUNNING] = mod;
        s[SW_RUN_ENABLE] = ren;
        s[SW_QUICK_STOP_N] = ~qs;
        s[SW_BREAKER_OK] = ~fb;
        s[SW_WARNING] = warn;
        s[SW_SETPOINT] = (dcm == dcr);
        s[SW_BUS_CONTROL] = w[CW_BUS_CONTROL];
        s[SW_ABOVE_LIMIT] = (dcm > dcl);
        s[SW_WATCHDOG] = w[CW_WATCHDOG];
        return s;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(92));
        cyc(4);
        arst_n = 1'b1;
        cyc(2);
        chk("contactors", 16'h0, {14'h0, pre, brk});
        $display("test reset done");
        // random levels, authority off so the watchdog is not supervised
        for (int n = 0; n < 40; n++) begin
            word = 16'($urandom) & 16'hfbff;
            {rdy, mod, ren, qs, warn, gen, fb} = 7'($urandom);
            rsel = 2'($urandom);
            dcm = 16'($urandom % 8);
            dcr = 16'($urandom % 8);
            dcl = 16'($urandom % 8);
            cyc(4);
            chk("status", exp_status(word), rep);
            chk("generation", {14'h0, mod, gen}, genw);
            chk("vin", {13'h0, word[14:12]}, {13'h0, v4, v3, v2});
            chk("relay", {15'h0, rsel == 2'h0 ? 1'b0 : word[CW_VIN_LO + rsel - 1]},
                {15'h0, rly});
        end
        {word, rdy, fb, dcm, dcl} = {16'h0000, 1'b0, 1'b0, 16'h0000, 16'h0064};
        $display("test status done");
        // every fault source, one at a time, flags accumulate
        acc = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            fsrc = 16'h0001 << i;
            acc = acc | fsrc;
            cyc(1);
            fsrc = 16'h0000;
            cyc(2);
            ef = exp_faults(acc);
            chk("fault1", ef[31:16], ff1);
            chk("fault2", ef[15:0], ff2);
            chk("fault bit", 16'h1, {15'h0, rep[SW_FAULT]});
        end
        word = 16'h0080;
        cyc(4);
        chk("fault clear", 16'h0, ff1 | ff2);
        fsrc[FS_EARTH] = 1'b1;
        cyc(1);
        fsrc = 16'h0000;
        cyc(6);
        chk("steady reset", 16'h0010, ff1);
        word = 16'h0000;
        cyc(4);
        word = 16'h0080;
        cyc(4);
        chk("fault clear", 16'h0, ff1);
        $display("test faults done");
        // precharge, automatic close, run, refusal without authority
        toggle = 1'b1;
        word = 16'h0401;
        wait_bit("precharge", 0, 1'b1, 6);
        cyc(1);
        chk("precharge bit", 16'h1, {15'h0, rep[SW_PRECHARGE]});
        chk("breaker early", 16'h0, {15'h0, brk});
        dcm = 16'h00c8;
        wait_bit("breaker", 1, 1'b1, 4);
        chk("precharge off", 16'h0, {15'h0, pre});
        {fb, rdy} = 2'b11;
        cyc(4);
        chk("ready run", 16'h0243, rep & 16'h0243);
        fb = 1'b0;
        cyc(4);
        chk("breaker bad", 16'h0201, rep & 16'h0243);
        fb = 1'b1;
        word = 16'h0409;
        wait_bit("run on", 2, 1'b1, 6);
        word = 16'h0401;
        wait_bit("run off", 2, 1'b0, 6);
        word = 16'h0009;
        wait_bit("no authority", 1, 1'b0, 6);
        chk("run refused", 16'h0, {15'h0, run});
        {fb, dcm} = {1'b0, 16'h0000};
        word = 16'h0401;
        wait_bit("precharge", 0, 1'b1, 6);
        word = 16'h0400;
        wait_bit("open", 0, 1'b0, 4);
        $display("test breaker done");
        // watchdog supervision while the bus holds authority
        cyc(120);
        chk("link ok", 16'h0, {15'h0, ff1[F1_FIELDBUS]});
        toggle = 1'b0;
        wait_bit("link lost", 3, 1'b1, TO_CYC + 20);
        word = 16'h0000;
        cyc(4);
        word = 16'h0080;
        cyc(4);
        chk("link clear", 16'h0, ff1);
        $display("test watchdog done");
        summarize();
    end
endmodule
